// ===== hw/sltc_pkg.sv
// Package: register map, field layout and modes of the link control register bank
package sltc_pkg;

  // ----------------------------------------
  // Serial control port
  // ----------------------------------------
  localparam int         ADDR_W       = 13;
  localparam int         INSTR_BITS   = 16;
  localparam int         DATA_BITS    = 8;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [12:0] OFS_PAT4_HI  = 13'h0_020;
  localparam logic [12:0] OFS_CMUL     = 13'h0_021;
  localparam logic [12:0] OFS_SIG_LO   = 13'h0_024;
  localparam logic [12:0] OFS_SIG_HI   = 13'h0_025;
  localparam logic [12:0] OFS_DIVSY    = 13'h0_03a;
  localparam logic [12:0] OFS_LINK1    = 13'h0_060;
  localparam logic [12:0] OFS_LINK2    = 13'h0_061;
  localparam logic [12:0] OFS_LINK3    = 13'h0_062;
  localparam logic [12:0] OFS_LINK4    = 13'h0_063;

  // ----------------------------------------
  // Reset values and writable bit masks
  // ----------------------------------------
  localparam logic [7:0]  RST_REG      = 8'h00;
  localparam logic [15:0] RST_SIG      = 16'h0000;
  localparam logic [7:0]  MASK_CMUL    = 8'h08;
  localparam logic [7:0]  MASK_DIVSY   = 8'h07;
  localparam logic [7:0]  MASK_LINK1   = 8'h7f;
  localparam logic [7:0]  MASK_LINK2   = 8'hf7;
  localparam logic [7:0]  MASK_LINK3   = 8'hb7;
  localparam logic [7:0]  MASK_FULL    = 8'hff;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int LOW_ENC_BIT     = 3;
  localparam int SYNC_BUF_BIT    = 0;
  localparam int DIV_SYNC_BIT    = 1;
  localparam int DIV_NEXT_BIT    = 2;
  localparam int LINK_PD_BIT     = 0;
  localparam int FRAME_CHR_BIT   = 1;
  localparam int ALIGN_LSB       = 2;
  localparam int LANE_SYNC_BIT   = 4;
  localparam int TEST_SMP_BIT    = 5;
  localparam int TAIL_BIT        = 6;
  localparam int MIRROR_BIT      = 0;
  localparam int INVERT_BIT      = 1;
  localparam int BYPASS_BIT      = 2;
  localparam int SYNC_CMOS_BIT   = 4;
  localparam int SYNC_INV_BIT    = 5;
  localparam int SYNC_MODE_LSB   = 6;
  localparam int TEST_MODE_LSB   = 0;
  localparam int INJECT_LSB      = 4;
  localparam int CSUM_DIS_BIT    = 7;

  // ----------------------------------------
  // Mode encodings
  // ----------------------------------------
  typedef enum logic [2:0] {
    TM_NORMAL    = 3'b000,
    TM_CHECKER   = 3'b001,
    TM_TOGGLE    = 3'b010,
    TM_PN_LONG   = 3'b011,
    TM_PN_SHORT  = 3'b100
  } sltc_test_mode_t;

  typedef enum logic [1:0] {
    ALIGN_OFF    = 2'b00,
    ALIGN_ON     = 2'b01,
    ALIGN_RSVD   = 2'b10,
    ALIGN_ALWAYS = 2'b11
  } sltc_align_mode_t;

  typedef enum logic [1:0] {
    SYNC_INDIV   = 2'b00,
    SYNC_GLOBAL  = 2'b01,
    SYNC_ACTIVE  = 2'b10,
    SYNC_IGNORE  = 2'b11
  } sltc_sync_mode_t;

  typedef enum logic [1:0] {
    INJ_SAMPLE   = 2'b00,
    INJ_ENCODED  = 2'b01
  } sltc_inject_t;

  typedef enum logic [1:0] {
    SPI_INSTR    = 2'b00,
    SPI_DATA     = 2'b01
  } sltc_spi_state_t;

endpackage : sltc_pkg

// ===== hw/sltc_regs.sv
// Link transmitter control register bank behind the three-wire serial control port
//
// Operation
// - Pattern four upper byte, bits 15:8, resets zero
// - Three-bit test mode selects output content
// - Alignment sequence mode: off, on, always on
// - Sync mode: individual, global, active, ignored
// - Sync standard bit and polarity invert bit
// - Injection: 16-bit at sample, 10-bit encoded
`timescale 1ns/100ps
`default_nettype none

module sltc_regs (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Serial control port
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sdio_in,
  output logic             spi_sdio_out,
  output logic             spi_sdio_oe,
  // Sync request inputs
  input  wire logic        sync_lvds_in,
  input  wire logic        sync_cmos_in,
  input  wire logic        divider_sync_in,
  // Self-test sample path
  input  wire logic        self_test_clear,
  input  wire logic        sample_valid,
  input  wire logic [13:0] sample_data,
  // Clock multiplier and divider
  output logic             low_encode_rate_en,
  output logic             divider_align,
  // Link control
  output logic [15:8]      user_pattern_four_hi,
  output logic             link_power_down,
  output logic             frame_char_insert_dis,
  output logic             align_seq_enable,
  output logic             align_seq_continuous,
  output logic             lane_sync_enable,
  output logic             test_sample_enable,
  output logic             tail_bit_enable,
  output logic             mirror_bits,
  output logic             invert_bits,
  output logic             bypass_8b10b,
  output logic [1:0]       sync_mode,
  output logic             link_sync_request_input,
  output logic             config_checksum_dis,
  output logic [2:0]       test_mode,
  output logic             test_active,
  output logic             inject_at_sample,
  output logic             inject_after_encoder,
  output logic [7:0]       align_repeat_count
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]  pat4_reg,  pat4_next;
  logic [7:0]  cmul_reg,  cmul_next;
  logic [7:0]  divsy_reg, divsy_next;
  logic [7:0]  link1_reg, link1_next;
  logic [7:0]  link2_reg, link2_next;
  logic [7:0]  link3_reg, link3_next;
  logic [7:0]  link4_reg, link4_next;
  logic [15:0] signature;

  // ----------------------------------------
  // Serial port state
  // ----------------------------------------
  sltc_pkg::sltc_spi_state_t st_reg, st_next;
  logic [4:0]  cnt_reg,   cnt_next;
  logic [15:0] sh_reg,    sh_next;
  logic [7:0]  rd_reg,    rd_next;
  logic [12:0] addr_reg,  addr_next;
  logic        read_reg,  read_next;
  logic        oe_reg,    oe_next;
  logic        dout_reg,  dout_next;
  logic        sclk_reg;
  logic        sync_prev_reg;
  logic        align_reg, align_next;

  logic        sclk_rise;
  logic        sclk_fall;
  logic        wr_en;
  logic [7:0]  wr_data;
  logic [12:0] next_addr;
  logic        sync_event;

  assign sclk_rise = spi_sclk & ~sclk_reg;
  assign sclk_fall = ~spi_sclk & sclk_reg;
  assign next_addr = addr_reg + 13'h0_001;
  assign wr_data   = {sh_reg[6:0], spi_sdio_in};

  function automatic logic [7:0] read_mux(input logic [12:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == sltc_pkg::OFS_PAT4_HI) begin
      d = pat4_reg;
    end else if (a == sltc_pkg::OFS_CMUL) begin
      d = cmul_reg;
    end else if (a == sltc_pkg::OFS_SIG_LO) begin
      d = signature[7:0];
    end else if (a == sltc_pkg::OFS_SIG_HI) begin
      d = signature[15:8];
    end else if (a == sltc_pkg::OFS_DIVSY) begin
      d = divsy_reg;
    end else if (a == sltc_pkg::OFS_LINK1) begin
      d = link1_reg;
    end else if (a == sltc_pkg::OFS_LINK2) begin
      d = link2_reg;
    end else if (a == sltc_pkg::OFS_LINK3) begin
      d = link3_reg;
    end else if (a == sltc_pkg::OFS_LINK4) begin
      d = link4_reg;
    end
    return d;
  endfunction : read_mux

  // ----------------------------------------
  // Serial control port engine
  // ----------------------------------------
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    sh_next   = sh_reg;
    rd_next   = rd_reg;
    addr_next = addr_reg;
    read_next = read_reg;
    oe_next   = oe_reg;
    dout_next = dout_reg;
    wr_en     = 1'b0;
    if (spi_cs_n) begin
      st_next  = sltc_pkg::SPI_INSTR;
      cnt_next = 5'd0;
      oe_next  = 1'b0;
    end else begin
      if (sclk_rise) begin
        sh_next  = {sh_reg[14:0], spi_sdio_in};
        cnt_next = cnt_reg + 5'd1;
        case (st_reg)
          sltc_pkg::SPI_INSTR: begin
            if (cnt_reg == 5'(sltc_pkg::INSTR_BITS - 1)) begin
              read_next = sh_reg[14];
              addr_next = {sh_reg[11:0], spi_sdio_in};
              rd_next   = read_mux({sh_reg[11:0], spi_sdio_in});
              oe_next   = sh_reg[14];
              st_next   = sltc_pkg::SPI_DATA;
              cnt_next  = 5'd0;
            end
          end
          sltc_pkg::SPI_DATA: begin
            if (cnt_reg == 5'(sltc_pkg::DATA_BITS - 1)) begin
              wr_en     = ~read_reg;
              addr_next = next_addr;
              rd_next   = read_mux(next_addr);
              cnt_next  = 5'd0;
            end
          end
          default: begin
            st_next = sltc_pkg::SPI_INSTR;
          end
        endcase
      end
      if (sclk_fall && st_reg == sltc_pkg::SPI_DATA && read_reg) begin
        dout_next = rd_reg[7];
        rd_next   = {rd_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg   <= sltc_pkg::SPI_INSTR;
      cnt_reg  <= 5'd0;
      sh_reg   <= 16'h0000;
      rd_reg   <= 8'h00;
      addr_reg <= 13'h0_000;
      read_reg <= 1'b0;
      oe_reg   <= 1'b0;
      dout_reg <= 1'b0;
      sclk_reg <= 1'b0;
    end else if (clk_en) begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      sh_reg   <= sh_next;
      rd_reg   <= rd_next;
      addr_reg <= addr_next;
      read_reg <= read_next;
      oe_reg   <= oe_next;
      dout_reg <= dout_next;
      sclk_reg <= spi_sclk;
    end
  end

  assign spi_sdio_out = dout_reg;
  assign spi_sdio_oe  = oe_reg;

  // ----------------------------------------
  // Register file and divider sync
  // ----------------------------------------
  // Divider sync pin passes only through the enabled master buffer
  assign sync_event = divsy_reg[sltc_pkg::SYNC_BUF_BIT] & divsy_reg[sltc_pkg::DIV_SYNC_BIT]
                    & divider_sync_in & ~sync_prev_reg;

  always_comb begin
    pat4_next  = pat4_reg;
    cmul_next  = cmul_reg;
    divsy_next = divsy_reg;
    link1_next = link1_reg;
    link2_next = link2_reg;
    link3_next = link3_reg;
    link4_next = link4_reg;
    align_next = sync_event;
    // One-shot alignment drops the enable; a same-cycle write wins
    if (sync_event && divsy_reg[sltc_pkg::DIV_NEXT_BIT]) begin
      divsy_next[sltc_pkg::DIV_SYNC_BIT] = 1'b0;
    end
    if (wr_en) begin
      if (addr_reg == sltc_pkg::OFS_PAT4_HI) begin
        pat4_next = wr_data & sltc_pkg::MASK_FULL;
      end else if (addr_reg == sltc_pkg::OFS_CMUL) begin
        cmul_next = wr_data & sltc_pkg::MASK_CMUL;
      end else if (addr_reg == sltc_pkg::OFS_DIVSY) begin
        divsy_next = wr_data & sltc_pkg::MASK_DIVSY;
      end else if (addr_reg == sltc_pkg::OFS_LINK1) begin
        link1_next = wr_data & sltc_pkg::MASK_LINK1;
      end else if (addr_reg == sltc_pkg::OFS_LINK2) begin
        link2_next = wr_data & sltc_pkg::MASK_LINK2;
      end else if (addr_reg == sltc_pkg::OFS_LINK3) begin
        link3_next = wr_data & sltc_pkg::MASK_LINK3;
      end else if (addr_reg == sltc_pkg::OFS_LINK4) begin
        link4_next = wr_data & sltc_pkg::MASK_FULL;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pat4_reg      <= sltc_pkg::RST_REG;
      cmul_reg      <= sltc_pkg::RST_REG;
      divsy_reg     <= sltc_pkg::RST_REG;
      link1_reg     <= sltc_pkg::RST_REG;
      link2_reg     <= sltc_pkg::RST_REG;
      link3_reg     <= sltc_pkg::RST_REG;
      link4_reg     <= sltc_pkg::RST_REG;
      align_reg     <= 1'b0;
      sync_prev_reg <= 1'b0;
    end else if (clk_en) begin
      pat4_reg      <= pat4_next;
      cmul_reg      <= cmul_next;
      divsy_reg     <= divsy_next;
      link1_reg     <= link1_next;
      link2_reg     <= link2_next;
      link3_reg     <= link3_next;
      link4_reg     <= link4_next;
      align_reg     <= align_next;
      sync_prev_reg <= divider_sync_in;
    end
  end

  // ----------------------------------------
  // Self-test signature
  // ----------------------------------------
  sltc_signature #(
    .WIDTH        (16),
    .POLY         (16'h1021)
  ) u_signature (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .clk_en       (clk_en),
    .clear        (self_test_clear),
    .sample_valid (sample_valid),
    .sample_data  ({2'b00, sample_data}),
    .signature    (signature)
  );

  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  logic [1:0] align_mode;
  logic       sync_raw;
  logic [1:0] inject_sel;

  assign align_mode = link1_reg[sltc_pkg::ALIGN_LSB +: 2];
  assign inject_sel = link3_reg[sltc_pkg::INJECT_LSB +: 2];

  assign low_encode_rate_en    = cmul_reg[sltc_pkg::LOW_ENC_BIT];
  assign divider_align         = align_reg;
  assign user_pattern_four_hi  = pat4_reg;
  assign link_power_down       = link1_reg[sltc_pkg::LINK_PD_BIT];
  assign frame_char_insert_dis = link1_reg[sltc_pkg::FRAME_CHR_BIT];
  assign align_seq_enable      = (align_mode == sltc_pkg::ALIGN_ON)
                               | (align_mode == sltc_pkg::ALIGN_ALWAYS);
  assign align_seq_continuous  = (align_mode == sltc_pkg::ALIGN_ALWAYS);
  assign lane_sync_enable      = link1_reg[sltc_pkg::LANE_SYNC_BIT];
  assign test_sample_enable    = link1_reg[sltc_pkg::TEST_SMP_BIT];
  assign tail_bit_enable       = link1_reg[sltc_pkg::TAIL_BIT];
  assign mirror_bits           = link2_reg[sltc_pkg::MIRROR_BIT];
  assign invert_bits           = link2_reg[sltc_pkg::INVERT_BIT];
  assign bypass_8b10b          = link2_reg[sltc_pkg::BYPASS_BIT];
  assign sync_mode             = link2_reg[sltc_pkg::SYNC_MODE_LSB +: 2];

  // Receiver choice, then polarity, then the ignore setting
  assign sync_raw = link2_reg[sltc_pkg::SYNC_CMOS_BIT] ? sync_cmos_in : sync_lvds_in;
  assign link_sync_request_input = (sync_mode != sltc_pkg::SYNC_IGNORE)
                                 & (sync_raw ^ link2_reg[sltc_pkg::SYNC_INV_BIT]);

  assign config_checksum_dis  = link3_reg[sltc_pkg::CSUM_DIS_BIT];
  // Reserved codes fall back to normal data
  assign test_mode = (link3_reg[2:0] > sltc_pkg::TM_PN_SHORT) ? sltc_pkg::TM_NORMAL
                   : link3_reg[sltc_pkg::TEST_MODE_LSB +: 3];
  assign test_active          = (test_mode != sltc_pkg::TM_NORMAL);
  assign inject_at_sample     = test_active & (inject_sel == sltc_pkg::INJ_SAMPLE);
  assign inject_after_encoder = test_active & (inject_sel == sltc_pkg::INJ_ENCODED);
  assign align_repeat_count   = link4_reg;

endmodule : sltc_regs

`default_nettype wire

// ===== hw/sltc_signature.sv
// Self-test signature register: 16-bit multiple-input shift register over sample words
`timescale 1ns/100ps
`default_nettype none

module sltc_signature #(
  parameter int          WIDTH = 16,
  parameter logic [15:0] POLY  = 16'h1021
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // Control
  input  wire logic             clear,
  input  wire logic             sample_valid,
  input  wire logic [WIDTH-1:0] sample_data,
  // Result
  output logic      [WIDTH-1:0] signature
);

  logic [WIDTH-1:0] sig_reg;
  logic [WIDTH-1:0] sig_next;

  always_comb begin
    sig_next = sig_reg;
    if (clear) begin
      sig_next = WIDTH'(sltc_pkg::RST_SIG);
    end else if (sample_valid) begin
      sig_next = {sig_reg[WIDTH-2:0], 1'b0} ^ sample_data
                 ^ (sig_reg[WIDTH-1] ? POLY[WIDTH-1:0] : '0);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sig_reg <= WIDTH'(sltc_pkg::RST_SIG);
    end else if (clk_en) begin
      sig_reg <= sig_next;
    end
  end

  assign signature = sig_reg;

endmodule : sltc_signature

`default_nettype wire

// ===== sim/sltc_regs_assertions.sv
// Port checker for the link control register bank
`timescale 1ns/100ps
`default_nettype none

module sltc_regs_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        sys_rst,
  // Watched ports
  input wire logic        spi_cs_n,
  input wire logic        divider_sync_in,
  input wire logic        divider_align,
  input wire logic [15:8] user_pattern_four_hi,
  input wire logic        align_seq_enable,
  input wire logic        align_seq_continuous,
  input wire logic [1:0]  sync_mode,
  input wire logic        link_sync_request_input,
  input wire logic [2:0]  test_mode,
  input wire logic        test_active,
  input wire logic        inject_at_sample,
  input wire logic        inject_after_encoder
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_cont;
    align_seq_continuous |-> align_seq_enable;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous alignment without enable");
  property p_act;
    test_active == (test_mode != 3'h0);
  endproperty
  a_act: assert property (p_act) else $error("test active flag wrong");
  property p_code;
    test_mode <= 3'h4;
  endproperty
  a_code: assert property (p_code) else $error("reserved test code shown");
  property p_inj;
    (inject_at_sample || inject_after_encoder)
      |-> test_active && !(inject_at_sample && inject_after_encoder);
  endproperty
  a_inj: assert property (p_inj) else $error("injection point wrong");
  property p_ign;
    sync_mode == 2'h3 |-> !link_sync_request_input;
  endproperty
  a_ign: assert property (p_ign) else $error("ignored sync pin passed");
  property p_rst;
    $fell(sys_rst) |-> user_pattern_four_hi == 8'h00 && test_mode == 3'h0 && sync_mode == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_hold;
    spi_cs_n && $past(spi_cs_n) |-> $stable(user_pattern_four_hi);
  endproperty
  a_hold: assert property (p_hold) else $error("pattern changed while idle");
  property p_pulse;
    divider_align |=> !divider_align;
  endproperty
  a_pulse: assert property (p_pulse) else $error("align pulse too long");
  property p_cause;
    divider_align |-> $past(divider_sync_in) && !$past(divider_sync_in, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("align without sync edge");

  c_align: cover property (divider_align);
  c_cont: cover property (align_seq_continuous);
  c_enc: cover property (inject_after_encoder);
endmodule : sltc_regs_chk

bind sltc_regs sltc_regs_chk u_chk (.clock, .sys_rst, .spi_cs_n, .divider_sync_in,
  .divider_align, .user_pattern_four_hi, .align_seq_enable, .align_seq_continuous,
  .sync_mode, .link_sync_request_input, .test_mode, .test_active, .inject_at_sample,
  .inject_after_encoder);

`default_nettype wire

// ===== sim/sltc_rx_model.sv
// Downstream link receiver model: drives the sync request on both receiver paths
`timescale 1ns/100ps
`default_nettype none

module sltc_rx_model (
  // Request from the bench
  input  wire logic req_level,
  input  wire logic use_cmos,
  // Sync request pins
  output logic      sync_lvds_in,
  output logic      sync_cmos_in
);
  // Unused path shows the inverse so a wrong receiver choice is seen
  assign sync_lvds_in = use_cmos ? ~req_level : req_level;
  assign sync_cmos_in = use_cmos ? req_level : ~req_level;
endmodule : sltc_rx_model

`default_nettype wire

// ===== sim/tb_sltc_regs.sv
// Testbench for the link control register bank
`timescale 1ns/100ps
`default_nettype none

module tb_sltc_regs;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        spi_sclk = 1'b0;
  logic        spi_cs_n = 1'b1;
  logic        host_sdio = 1'b0;
  logic        divider_sync_in = 1'b0;
  logic        st_clear = 1'b0;
  logic        smp_valid = 1'b0;
  logic [13:0] smp_data = 14'h0000;
  logic        req_lvl = 1'b0;
  logic        req_cmos = 1'b0;
  logic        ce = 1'b1;
  logic        spi_sdio_out, spi_sdio_oe, sync_lvds_in, sync_cmos_in;
  logic        low_encode_rate_en, divider_align, align_seq_enable, align_seq_continuous;
  logic        link_sync_request_input, test_active, inject_at_sample, inject_after_encoder;
  logic [15:8] user_pattern_four_hi;
  logic [1:0]  sync_mode;
  logic [2:0]  test_mode;
  logic        lk_pd, lk_fc, lk_ls, lk_ts, lk_tb, lk_mi, lk_iv, lk_bp, lk_cs;
  logic [7:0]  rep_cnt;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  wire logic   spi_sdio_in = spi_sdio_oe ? spi_sdio_out : host_sdio;

  localparam logic [12:0] ADR [10] = '{13'h0_020, 13'h0_021, 13'h0_024, 13'h0_025,
    13'h0_03a, 13'h0_060, 13'h0_061, 13'h0_062, 13'h0_063, 13'h0_030};
  localparam logic [7:0] MSK [10] = '{8'hff, 8'h08, 8'h00, 8'h00, 8'h07, 8'h7f, 8'hf7,
    8'hb7, 8'hff, 8'h00};

  always #5 clock = ~clock;

  sltc_rx_model u_rx (.req_level(req_lvl), .use_cmos(req_cmos), .sync_lvds_in, .sync_cmos_in);

  sltc_regs u_dut (.clock, .sys_rst, .clk_en(ce), .spi_sclk, .spi_cs_n, .spi_sdio_in,
    .spi_sdio_out, .spi_sdio_oe, .sync_lvds_in, .sync_cmos_in, .divider_sync_in,
    .self_test_clear(st_clear), .sample_valid(smp_valid), .sample_data(smp_data),
    .low_encode_rate_en, .divider_align, .user_pattern_four_hi, .link_power_down(lk_pd),
    .frame_char_insert_dis(lk_fc), .align_seq_enable, .align_seq_continuous,
    .lane_sync_enable(lk_ls), .test_sample_enable(lk_ts), .tail_bit_enable(lk_tb),
    .mirror_bits(lk_mi), .invert_bits(lk_iv), .bypass_8b10b(lk_bp), .sync_mode,
    .link_sync_request_input, .config_checksum_dis(lk_cs), .test_mode, .test_active,
    .inject_at_sample, .inject_after_encoder, .align_repeat_count(rep_cnt));

  // ----------------------------------------
  // Compare and serial port tasks
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  function automatic logic [2:0] tm(input logic [2:0] c);
    return (c > 3'h4) ? 3'h0 : c;
  endfunction : tm

  // One bit: low phase of 4 clocks, read data taken late in it, high phase of 3
  task automatic bit_io(input logic b, output logic r);
    @(posedge clock);
    spi_sclk  <= 1'b0;
    host_sdio <= b;
    repeat (3) @(posedge clock);
    #1 r = spi_sdio_oe ? spi_sdio_out : 1'bx;
    @(posedge clock);
    spi_sclk <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : bit_io

  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [15:0] ins;
    logic        r;
    ins = {rd, 2'b00, a};
    @(posedge clock);
    spi_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
      bit_io(ins[i], r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    @(posedge clock);
    spi_cs_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : xfer

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b0, a, d, q);
  endtask : wr

  task automatic rdchk(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] q;
    xfer(1'b1, a, 8'h00, q);
    chk8(q, exp);
    chk1(spi_sdio_oe, 1'b0);
  endtask : rdchk

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_map(input logic [7:0] d);
    for (int i = 0; i < 10; i++)
      wr(ADR[i], d);
    for (int i = 0; i < 10; i++)
      rdchk(ADR[i], d & MSK[i]);
    chk8(user_pattern_four_hi, d);
    chk1(low_encode_rate_en, d[3]);
    chk8({6'h00, sync_mode}, {6'h00, d[7:6]});
    chk1(align_seq_continuous, d[3] & d[2]);
    chk8({5'h00, test_mode}, {5'h00, tm(d[2:0])});
    chk1(inject_after_encoder, tm(d[2:0]) != 3'h0 && d[5:4] == 2'b01);
    chk8({1'b0, lk_tb, lk_ts, lk_ls, 2'b00, lk_fc, lk_pd}, d & 8'h73);
    chk8({5'h00, lk_bp, lk_iv, lk_mi}, {5'h00, d[2:0]});
    chk1(lk_cs, d[7]);
    chk8(rep_cnt, d);
  endtask : t_map

  task automatic t_codes;
    for (int c = 0; c < 8; c++) begin
      wr(13'h0_062, {3'b000, c[0], 1'b0, c[2:0]});
      chk8({5'h00, test_mode}, {5'h00, tm(c[2:0])});
      chk1(test_active, tm(c[2:0]) != 3'h0);
      chk1(inject_at_sample, tm(c[2:0]) != 3'h0 && !c[0]);
      chk1(inject_after_encoder, tm(c[2:0]) != 3'h0 && c[0]);
    end
  endtask : t_codes

  task automatic t_align;
    for (int m = 0; m < 4; m++) begin
      wr(13'h0_060, {4'h0, m[1:0], 2'b00});
      chk1(align_seq_enable, m[0]);
      chk1(align_seq_continuous, m == 3);
    end
  endtask : t_align

  task automatic t_sync;
    for (int i = 0; i < 32; i++) begin
      req_lvl  <= i[0];
      req_cmos <= i[1];
      wr(13'h0_061, {i[4:3], i[2], i[1], 4'h0});
      chk1(link_sync_request_input, i[4:3] != 2'b11 && (i[0] ^ i[2]));
      chk8({6'h00, sync_mode}, {6'h00, i[4:3]});
    end
  endtask : t_sync

  task automatic t_div(input logic w, input logic [7:0] cfg, input int n_exp);
    int n;
    n = 0;
    if (w) begin
      wr(13'h0_03a, cfg);
    end
    divider_sync_in <= 1'b1;
    repeat (8) begin
      @(posedge clock);
      #1 n += int'(divider_align === 1'b1);
    end
    @(posedge clock);
    divider_sync_in <= 1'b0;
    chk8(8'(n), 8'(n_exp));
    repeat (3) @(posedge clock);
  endtask : t_div

  task automatic t_sig;
    st_clear <= 1'b1;
    @(posedge clock);
    st_clear  <= 1'b0;
    smp_valid <= 1'b1;
    smp_data  <= 14'h1234;
    @(posedge clock);
    smp_data <= 14'h0001;
    @(posedge clock);
    // Clock enable low must freeze the signature despite a valid sample
    ce       <= 1'b0;
    smp_data <= 14'h3fff;
    @(posedge clock);
    ce        <= 1'b1;
    smp_valid <= 1'b0;
    rdchk(13'h0_024, 8'h69);
    rdchk(13'h0_025, 8'h24);
  endtask : t_sig

  // ----------------------------------------
  // Sequence and timeout
  // ----------------------------------------
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    t_map(8'h00);
    t_map(8'h5c);
    t_map(8'ha3);
    t_codes();
    t_align();
    t_sync();
    t_div(1'b1, 8'h01, 0);
    t_div(1'b1, 8'h03, 1);
    t_div(1'b1, 8'h07, 1);
    rdchk(13'h0_03a, 8'h05);
    t_div(1'b0, 8'h00, 0);
    t_sig();
    close_out();
  end
endmodule : tb_sltc_regs

`default_nettype wire
